// File: rtl/spmsp_pkg.sv
// constants and register layout of the serial peripheral port
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package spmsp_pkg;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [5:0] SPMSP_IDX_DATA = 6'h31;
    localparam logic [5:0] SPMSP_IDX_CTRL = 6'h32;
    localparam logic [5:0] SPMSP_IDX_STAT = 6'h33;

    // ------------------------------------------------------------------
    // serial_port_control fields
    // ------------------------------------------------------------------
    localparam int SPMSP_C_IE = 7;
    localparam int SPMSP_C_PE = 6;
    localparam int SPMSP_C_DIV = 5;
    localparam int SPMSP_C_MASTER = 4;
    localparam int SPMSP_C_CLOCK_IDLE_LEVEL = 3;
    localparam int SPMSP_C_CAPTURE_EDGE_SELECT = 2;
    localparam int SPMSP_C_RATE_HI = 1;
    localparam int SPMSP_C_RATE_LO = 0;
    localparam logic [7:0] SPMSP_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // serial_port_control_status fields
    // ------------------------------------------------------------------
    localparam int SPMSP_S_TCF = 7;
    localparam int SPMSP_S_WRITE_COLLISION_FLAG = 6;
    localparam int SPMSP_S_OVR = 5;
    localparam int SPMSP_S_MODE_FAULT_FLAG = 4;
    localparam int SPMSP_S_SOD = 2;
    localparam int SPMSP_S_SSM = 1;
    localparam int SPMSP_S_SSI = 0;
    localparam logic [2:0] SPMSP_STAT_RESET = 3'h0;

    // ------------------------------------------------------------------
    // master clock divisors of the cpu clock
    // ------------------------------------------------------------------
    localparam int SPMSP_DIV_4 = 4;
    localparam int SPMSP_DIV_8 = 8;
    localparam int SPMSP_DIV_16 = 16;
    localparam int SPMSP_DIV_32 = 32;
    localparam int SPMSP_DIV_64 = 64;
    localparam int SPMSP_DIV_128 = 128;
    localparam logic [3:0] SPMSP_LAST_EDGE = 4'hf;

endpackage : spmsp_pkg

// File: rtl/spmsp_top.sv
// serial peripheral port, master or slave, with classic wishbone registers
`timescale 1ns/1ps
module spmsp_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial clock pin
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    // data pins
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    // slave select pin, active low
    input wire logic ss_n_i,
    // low power and interrupt
    input wire logic halt_mode,
    output logic irq,
    output logic halt_wake
);
    import spmsp_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sck_sync;
    logic [1:0] mosi_sync;
    logic [1:0] miso_sync;
    logic [1:0] ss_sync;
    logic sck_prev;

    // two stages each; only stage 1 feeds logic
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sck_sync <= 2'h0;
            mosi_sync <= 2'h0;
            miso_sync <= 2'h0;
            ss_sync <= 2'h3;
            sck_prev <= 1'b0;
        end else begin
            sck_sync <= {sck_sync[0], sck_i};
            mosi_sync <= {mosi_sync[0], mosi_i};
            miso_sync <= {miso_sync[0], miso_i};
            ss_sync <= {ss_sync[0], ss_n_i};
            sck_prev <= sck_sync[1];
        end
    end

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [7:0] ctrl;
    logic tcf, write_collision_flag, overrun_flag, mode_fault_flag;
    logic sod, ssm, soft_select_level;
    logic tcf_armed, write_collision_flag_armed, mode_fault_flag_armed;
    logic [7:0] rx_buf;
    logic [7:0] shreg;
    logic out_bit;
    logic busy;
    logic [3:0] edge_cnt;
    logic sck_lvl;
    logic [6:0] div_cnt;
    logic done;
    logic tail;
    logic [2:0] cap_dly;
    logic halt_ok;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic req, wr, rd, lane0;
    logic hit_data, hit_ctrl, hit_stat;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;
    assign lane0 = wb_sel_i[0];
    assign hit_data = wb_adr_i[7:2] == SPMSP_IDX_DATA;
    assign hit_ctrl = wb_adr_i[7:2] == SPMSP_IDX_CTRL;
    assign hit_stat = wb_adr_i[7:2] == SPMSP_IDX_STAT;

    // ------------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------------
    logic pe, master, capture_edge_select, clock_idle_level, ie;
    logic ss_int, master_on, slave_on, in_xfer;
    logic data_wr, data_rd, data_acc, stat_acc, stat_rd, ctrl_wr;
    logic collide, load, fault;
    logic [6:0] half;
    logic m_tick, s_edge, edge_ev, din;

    assign pe = ctrl[SPMSP_C_PE];
    assign master = ctrl[SPMSP_C_MASTER];
    assign capture_edge_select = ctrl[SPMSP_C_CAPTURE_EDGE_SELECT];
    assign clock_idle_level = ctrl[SPMSP_C_CLOCK_IDLE_LEVEL];
    assign ie = ctrl[SPMSP_C_IE];
    // software select replaces the pin when chosen
    assign ss_int = ssm ? soft_select_level : ss_sync[1];
    assign master_on = pe & master;
    assign slave_on = pe & ~master;
    assign data_wr = wr & lane0 & hit_data;
    assign data_rd = rd & hit_data;
    assign data_acc = req & hit_data;
    assign stat_acc = req & hit_stat;
    assign stat_rd = rd & hit_stat;
    assign ctrl_wr = wr & lane0 & hit_ctrl;

    // a slave with phase 0 and select low may not touch the shifter
    assign in_xfer = master ? busy
                   : ((edge_cnt != 4'h0) | (~capture_edge_select & ~ss_int));
    assign collide = data_wr & pe & in_xfer;
    // complete flag blocks writes until status accessed
    assign load = data_wr & ~collide & ~(tcf & ~tcf_armed);

    // rate select, ignored in slave mode
    always_comb begin
        unique case ({ctrl[SPMSP_C_DIV], ctrl[SPMSP_C_RATE_HI],
                      ctrl[SPMSP_C_RATE_LO]})
            3'h4: half = 7'(SPMSP_DIV_4 / 2);
            3'h0: half = 7'(SPMSP_DIV_8 / 2);
            3'h1: half = 7'(SPMSP_DIV_16 / 2);
            3'h6: half = 7'(SPMSP_DIV_32 / 2);
            3'h2: half = 7'(SPMSP_DIV_64 / 2);
            default: half = 7'(SPMSP_DIV_128 / 2);
        endcase
    end

    // halt freezes the master clock generator
    assign m_tick = master_on & busy & ~halt_mode & ~tail
                  & (div_cnt == half - 7'h1);
    // a halted slave runs only if it was selected at halt entry
    assign s_edge = slave_on & ~ss_int & (sck_sync[1] != sck_prev)
                  & (~halt_mode | halt_ok);
    assign edge_ev = m_tick | s_edge;
    assign din = master ? miso_sync[1] : mosi_sync[1];
    assign fault = master_on & ~ss_int & ~halt_mode;

    // ------------------------------------------------------------------
    // master clock divider
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_cnt <= 7'h0;
        end else if (load | ~busy | ~master_on) begin
            div_cnt <= 7'h0;
        end else if (~halt_mode) begin
            div_cnt <= m_tick ? 7'h0 : div_cnt + 7'h1;
        end
    end

    // ------------------------------------------------------------------
    // shift engine, sixteen clock edges per byte
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shreg <= 8'h00;
            out_bit <= 1'b0;
            busy <= 1'b0;
            edge_cnt <= 4'h0;
            sck_lvl <= 1'b0;
            done <= 1'b0;
            tail <= 1'b0;
            cap_dly <= 3'h0;
        end else begin
            done <= 1'b0;
            // a master bit returns through the clock register and two
            // sync flops, so it is put in place three cycles late
            cap_dly <= {cap_dly[1:0], m_tick & (edge_cnt[0] == capture_edge_select)};
            if (load) begin
                shreg <= wb_dat_i[7:0];
                out_bit <= wb_dat_i[7];
                busy <= master_on;
                edge_cnt <= 4'h0;
                sck_lvl <= clock_idle_level;
                tail <= 1'b0;
                cap_dly <= 3'h0;
            end else if (~pe) begin
                // disabled or faulted: drop any byte in flight
                busy <= 1'b0;
                edge_cnt <= 4'h0;
                sck_lvl <= clock_idle_level;
                tail <= 1'b0;
                cap_dly <= 3'h0;
            end else if (edge_ev) begin
                if (edge_cnt[0] == capture_edge_select) begin
                    shreg <= {shreg[6:0], ~master & din};
                end else begin
                    out_bit <= shreg[7];
                end
                edge_cnt <= edge_cnt + 4'h1;
                if (master) begin
                    sck_lvl <= ~sck_lvl;
                end
                if (edge_cnt == SPMSP_LAST_EDGE) begin
                    // a master waits for its last late bit
                    tail <= master;
                    done <= ~master;
                end
            end else begin
                if (tail & (cap_dly == 3'h0)) begin
                    done <= 1'b1;
                    busy <= 1'b0;
                    tail <= 1'b0;
                end
                if (~master & ss_int) begin
                    edge_cnt <= 4'h0;
                end
                if (~busy) begin
                    sck_lvl <= clock_idle_level;
                end
            end
            if (cap_dly[2] & pe & ~load) begin
                shreg[0] <= din;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register, with fault handling
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= SPMSP_CTRL_RESET;
        end else if (fault) begin
            ctrl[SPMSP_C_PE] <= 1'b0;
            ctrl[SPMSP_C_MASTER] <= 1'b0;
        end else if (ctrl_wr) begin
            ctrl <= wb_dat_i[7:0];
            if (mode_fault_flag & ~mode_fault_flag_armed) begin
                // no enable or master while a fault is pending
                ctrl[SPMSP_C_PE] <= wb_dat_i[SPMSP_C_PE] & pe;
                ctrl[SPMSP_C_MASTER] <= wb_dat_i[SPMSP_C_MASTER] & master;
            end
        end
    end

    // status register writable bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            {sod, ssm, soft_select_level} <= SPMSP_STAT_RESET;
        end else if (wr & lane0 & hit_stat) begin
            sod <= wb_dat_i[SPMSP_S_SOD];
            ssm <= wb_dat_i[SPMSP_S_SSM];
            soft_select_level <= wb_dat_i[SPMSP_S_SSI];
        end
    end

    // ------------------------------------------------------------------
    // flags; a setting event always wins over a clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tcf <= 1'b0;
            tcf_armed <= 1'b0;
            overrun_flag <= 1'b0;
            rx_buf <= 8'h00;
        end else begin
            if (done & tcf) begin
                overrun_flag <= 1'b1;
            end else if (stat_rd) begin
                overrun_flag <= 1'b0;
            end
            if (done & ~tcf) begin
                // later bytes are lost while the flag stands
                rx_buf <= shreg;
            end
            if (done) begin
                tcf <= 1'b1;
                tcf_armed <= 1'b0;
            end else if (data_acc & tcf_armed) begin
                tcf <= 1'b0;
                tcf_armed <= 1'b0;
            end else if (stat_acc & tcf) begin
                tcf_armed <= 1'b1;
            end
        end
    end

    // write collision: status only, cleared by status then data read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            write_collision_flag <= 1'b0;
            write_collision_flag_armed <= 1'b0;
        end else if (collide) begin
            write_collision_flag <= 1'b1;
            write_collision_flag_armed <= 1'b0;
        end else if (data_rd & write_collision_flag_armed) begin
            write_collision_flag <= 1'b0;
            write_collision_flag_armed <= 1'b0;
        end else if (stat_rd & write_collision_flag) begin
            write_collision_flag_armed <= 1'b1;
        end
    end

    // mode fault flag and its clearing sequence
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed <= 1'b0;
        end else if (fault) begin
            mode_fault_flag <= 1'b1;
            mode_fault_flag_armed <= 1'b0;
        end else if (ctrl_wr & mode_fault_flag_armed) begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed <= 1'b0;
        end else if (stat_rd & mode_fault_flag) begin
            mode_fault_flag_armed <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // halt entry: remember whether the slave was selected
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            halt_ok <= 1'b0;
        end else if (~halt_mode) begin
            halt_ok <= slave_on & ~ss_int;
        end
    end

    // ------------------------------------------------------------------
    // interrupt request and halt wakeup
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq <= 1'b0;
            halt_wake <= 1'b0;
        end else begin
            // runs in wait as well, so any event except write collision wakes the cpu
            irq <= ie & (tcf | mode_fault_flag | overrun_flag);
            // only transfer complete leaves halt
            halt_wake <= halt_mode & halt_ok & ie & tcf;
        end
    end

    // ------------------------------------------------------------------
    // pin drivers; nothing driven while the port is off
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            sck_o <= master_on ? sck_lvl : clock_idle_level;
            sck_oe <= master_on;
            mosi_o <= out_bit;
            mosi_oe <= master_on & ~sod;
            miso_o <= out_bit;
            // a deselected slave leaves the shared line alone
            miso_oe <= slave_on & ~sod & ~ss_int;
        end
    end

    // ------------------------------------------------------------------
    // wishbone answer: one wait state, unmapped reads give zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                unique case (1'b1)
                    hit_data: wb_dat_o <= {24'h000000, rx_buf};
                    hit_ctrl: wb_dat_o <= {24'h000000, ctrl};
                    hit_stat: wb_dat_o <= {24'h000000, tcf, write_collision_flag, overrun_flag,
                                           mode_fault_flag, 1'b0, sod, ssm, soft_select_level};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // spmsp_top

// File: tb/spi_master_slave_port_test.sv
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module spi_master_slave_port_test;
    import spmsp_pkg::*;
    localparam logic [7:0] A_D = {SPMSP_IDX_DATA, 2'b00};
    localparam logic [7:0] A_C = {SPMSP_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_S = {SPMSP_IDX_STAT, 2'b00};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pm_miso;
    logic sck_tb = 1'b0;
    logic mosi_tb = 1'b0;
    logic ss_n = 1'b1;
    logic sel_n = 1'b1;
    logic halt = 1'b0;
    logic capture_edge_select = 1'b0;
    logic irq, halt_wake;
    logic [7:0] ptx = 8'h00;
    logic [7:0] prx;
    logic [7:0] tx, pb, rb;
    logic [32:0] expq[$];
    logic [32:0] e;
    logic sck_p = 1'b0;
    int cnt = 0;
    int half = 0;
    int num_errors = 0;
    int n_compared = 0;
    wire sck_w = sck_oe ? sck_o : sck_tb;
    wire mosi_w = mosi_oe ? mosi_o : mosi_tb;
    wire miso_w = miso_oe ? miso_o : pm_miso;
    logic [2:0] rc[6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
    int dv[6] = '{SPMSP_DIV_4, SPMSP_DIV_8, SPMSP_DIV_16, SPMSP_DIV_32,
        SPMSP_DIV_64, SPMSP_DIV_128};

    spmsp_top DUT (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n),
        .halt_mode(halt), .irq(irq), .halt_wake(halt_wake));
    spmsp_slave_model u_slv (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n),
        .miso(pm_miso), .capture_edge_select(capture_edge_select), .tx_byte(ptx), .rx_byte(prx));

    // -------------------------------------------------------------
    // clock, comparison and closing
    // -------------------------------------------------------------
    initial forever #25 clk_sys = ~clk_sys;
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // read data judged at the edge that carries ack
    always @(posedge clk_sys) begin
        if (ack === 1'b1 && cyc && !we && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[32]) check("rdata", rdat, e[31:0]);
        end
    end
    // serial clock half period in system cycles
    always @(posedge clk_sys) begin
        cnt <= cnt + 1;
        if (sck_o !== sck_p) begin
            half <= cnt + 1;
            cnt <= 0;
        end
        sck_p <= sck_o;
    end
    // -------------------------------------------------------------
    // bus and serial tasks
    // -------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk_sys); while (ack !== 1'b1);
        cyc <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, exp, input logic chk);
        expq.push_back({chk, 24'h0, exp});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic wirq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 4000) begin
            @(posedge clk_sys);
            k++;
        end
        check("irq", irq, 1);
    endtask
    // bit-banged master byte, idle low, capture on first edge
    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            mosi_tb <= b[i];
            repeat (4) @(posedge clk_sys);
            sck_tb <= 1'b1;
            repeat (4) @(posedge clk_sys);
            rb = {rb[6:0], miso_w};
            sck_tb <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        mosi_tb <= ~b[0];
        repeat (8) @(posedge clk_sys);
    endtask

    // -------------------------------------------------------------
    // watchdog and main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end
    initial begin
        pb = $urandom(93);
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(A_C, SPMSP_CTRL_RESET, 1);
        rd(A_S, 8'h00, 1);
        rd(8'h00, 8'h00, 1);
        // master bytes over every divisor and phase setting
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, A_C, 8'h00);
            capture_edge_select <= i[0];
            bus(1'b1, A_C, {2'b11, rc[i][2], 1'b1, i[1], i[0], rc[i][1:0]});
            // the pin follows the new polarity two cycles after the write
            repeat (2) @(posedge clk_sys);
            check("sck_idle", sck_o, i[1]);
            tx = $urandom;
            pb = $urandom;
            ptx <= pb;
            sel_n <= 1'b0;
            @(posedge clk_sys);
            bus(1'b1, A_D, tx);
            wirq();
            rd(A_S, 8'h80, 1);
            rd(A_D, pb, 1);
            check("slave_rx", prx, tx);
            check("half", half, dv[i] / 2);
            check("irq_clr", irq, 0);
            sel_n <= 1'b1;
        end
        // slave: overrun, then write collision
        bus(1'b1, A_C, 8'h00);
        ss_n <= 1'b0;
        bus(1'b1, A_C, 8'hc0);
        tx = $urandom;
        sbyte(tx);
        sbyte(~tx);
        check("slave_tx", rb, tx);
        rd(A_S, 8'ha0, 1);
        rd(A_D, tx, 1);
        rd(A_S, 8'h00, 1);
        bus(1'b1, A_D, 8'h55);
        rd(A_S, 8'h40, 1);
        check("write_collision_flag_irq", irq, 0);
        rd(A_D, 8'h00, 0);
        rd(A_S, 8'h00, 1);
        // halted slave woken by a completed byte
        halt <= 1'b1;
        tx = $urandom;
        repeat (4) @(posedge clk_sys);
        sbyte(tx);
        wirq();
        @(posedge clk_sys);
        check("halt_wake", halt_wake, 1);
        halt <= 1'b0;
        rd(A_S, 8'h80, 1);
        rd(A_D, tx, 1);
        // master mode fault and its clearing sequence
        ss_n <= 1'b1;
        bus(1'b1, A_C, 8'h00);
        bus(1'b1, A_C, 8'hd0);
        ss_n <= 1'b0;
        wirq();
        bus(1'b1, A_C, 8'hd0);
        rd(A_C, 8'h80, 1);
        rd(A_S, 8'h10, 1);
        ss_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bus(1'b1, A_C, 8'hd0);
        rd(A_C, 8'hd0, 1);
        rd(A_S, 8'h00, 1);
        final_report();
    end
endmodule // spi_master_slave_port_test

// File: tb/spmsp_chk.sv
// assertion checker for the serial peripheral port top
`timescale 1ns/1ps
module spmsp_chk
    import spmsp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // bus
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // pins and events
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_i,
    input wire logic halt_mode,
    input wire logic irq,
    input wire logic halt_wake
);
    logic ie_sh;
    logic pe_ms_sh;
    logic ctl_wr;

    // -------------------------------------------------------------
    // shadow of control bits as written
    // -------------------------------------------------------------
    // hardware clears are not mirrored, so only implications toward it
    assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
        && (wb_adr_i[7:2] == SPMSP_IDX_CTRL);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ie_sh <= 1'b0;
            pe_ms_sh <= 1'b0;
        end else if (ctl_wr) begin
            ie_sh <= wb_dat_i[SPMSP_C_IE];
            pe_ms_sh <= wb_dat_i[SPMSP_C_PE] & wb_dat_i[SPMSP_C_MASTER];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // -------------------------------------------------------------
    // properties
    // -------------------------------------------------------------
    property p_irq_gate;
        irq |-> ie_sh;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq high with interrupts disabled");
    property p_oe_enable;
        (sck_oe || mosi_oe) |-> pe_ms_sh;
    endproperty
    a_oe_enable: assert property (p_oe_enable)
        else $error("master pins driven while not enabled master");
    property p_roles;
        miso_oe |-> !sck_oe;
    endproperty
    a_roles: assert property (p_roles)
        else $error("slave data out driven in master mode");
    property p_fault_off;
        $fell(ss_n_i) && sck_oe |-> ##[1:6] (!sck_oe && !mosi_oe);
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("mode fault did not release master pins");
    property p_fault_irq;
        $fell(ss_n_i) && sck_oe && ie_sh |-> ##[1:8] irq;
    endproperty
    a_fault_irq: assert property (p_fault_irq)
        else $error("mode fault raised no interrupt");
    property p_half;
        sck_oe && $changed(sck_o) |=> !sck_oe || $stable(sck_o);
    endproperty
    a_half: assert property (p_half)
        else $error("serial clock half period below two cycles");
    property p_wake;
        halt_wake |-> irq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without transfer complete interrupt");
    property p_halt;
        halt_mode && $past(halt_mode) && $past(halt_mode, 2)
            |-> $stable(sck_o);
    endproperty
    a_halt: assert property (p_halt)
        else $error("serial clock moved while halted");

    c_fault: cover property ($fell(sck_oe));
    c_irq: cover property ($rose(irq));
    c_wake: cover property (halt_wake);
endmodule // spmsp_chk

bind spmsp_top spmsp_chk u_chk (.clk_sys(clk_sys), .reset(reset),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
    .ss_n_i(ss_n_i), .halt_mode(halt_mode), .irq(irq),
    .halt_wake(halt_wake));

// File: tb/spmsp_slave_model.sv
// behavioural external slave facing the port in master mode
`timescale 1ns/1ps
module spmsp_slave_model (
    // serial lines
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso,
    // settings and data
    input wire logic capture_edge_select,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    int edges = 0;
    int idx = 0;
    logic [7:0] txl = 8'h00;

    initial miso = 1'b0;
    initial rx_byte = 8'h00;

    // selection: preload first bit for phase 0, else stale inverse
    always @(sel_n) begin
        edges = 0;
        txl = tx_byte;
        idx = capture_edge_select ? 7 : 6;
        if (!sel_n && !capture_edge_select) miso = txl[7];
        else miso = ~miso;
    end

    // same phase as the master; capture and drive on opposite edges
    always @(sck) begin
        if (!sel_n) begin
            edges = edges + 1;
            if ((edges % 2 == 1) != capture_edge_select) begin
                rx_byte = {rx_byte[6:0], mosi};
            end else begin
                miso = (idx >= 0) ? txl[idx] : ~miso;
                idx = idx - 1;
            end
        end
    end
endmodule // spmsp_slave_model
